// ===== common/efi_pkg.sv
`default_nettype none
package efi_pkg;
  // Clock rate, interrupt pin timing and transmit time-out
  localparam int CLK_MHZ         = 100;
  localparam int T_INT_ACT_US    = 100;
  localparam int T_INT_INACT_US  = 1000;
  localparam int T_TXD_TO_US     = 1000;
  localparam int INT_ACT_CYC     = T_INT_ACT_US * CLK_MHZ;
  localparam int INT_INACT_CYC   = T_INT_INACT_US * CLK_MHZ;
  localparam int TXD_TO_CYC      = T_TXD_TO_US * CLK_MHZ;
  localparam int CNT_W           = 24;
  // Event flag positions in event_status_reg_a
  localparam int EV_N            = 12;
  localparam int EV_CAN_TO       = 0;
  localparam int EV_BUCK_UNREG   = 3;
  localparam int EV_WD           = 8;
  localparam int EV_AUX_UNDER    = 9;
  localparam int EV_AUX_OVER     = 10;
  localparam int EV_FRAME        = 11;
  // Wake flag positions in wake_status_reg_b: local, can, lin1, lin2, timer
  localparam int WK_N            = 5;
  // Live conditions: buck unreg, buck ol, boost run, boost ol, twar, under, over
  localparam int ST_N            = 7;
  localparam logic [EV_N-1:0] FLAG_RST = 12'h000;
  localparam logic [EV_N-1:0] MASK_RST = 12'h000;
  localparam logic [EV_N-1:0] WD_BIT   = 12'h100;
  localparam logic [WK_N-1:0] WAKE_RST = 5'h00;
  // Serial frame length and counter saturation
  localparam logic [4:0] SPI_BITS    = 5'h10;
  localparam logic [4:0] SPI_CNT_MAX = 5'h11;
  typedef enum logic [2:0] {
    EFI_IDLE = 3'b001,
    EFI_LOW  = 3'b010,
    EFI_GAP  = 3'b100
  } efi_irq_e;
endpackage
`default_nettype wire

// ===== common/efi_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
interface efi_frame_if;
  logic cs_n;
  logic sck;
  logic frame_err;
  modport mon (output cs_n, output sck, input frame_err);
  modport chk (input cs_n, input sck, output frame_err);
endinterface
`default_nettype wire

// ===== hw/efi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module efi_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } efi_sync_s;
  efi_sync_s r;
  efi_sync_s next_r;

  // First stage is read only by the second stage
  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '{s1: RV, s2: RV};
    else
      r <= next_r;
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// ===== hw/efi_frame_chk.sv
`timescale 1ns/1ps
`default_nettype none
module efi_frame_chk
  import efi_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  efi_frame_if.chk  fr
);
  typedef struct packed {
    logic       cs_q;
    logic       sck_q;
    logic [4:0] cnt;
    logic       err;
  } efi_frame_s;
  efi_frame_s r;
  efi_frame_s next_r;

  // Counts falling clock edges inside a select-low frame
  always_comb
  begin
    next_r       = r;
    next_r.err   = 1'b0;
    next_r.cs_q  = fr.cs_n;
    next_r.sck_q = fr.sck;
    if (fr.cs_n != r.cs_q)
    begin
      if (fr.sck || r.sck_q)
        next_r.err = 1'b1;
      if (fr.cs_n && r.cnt != 5'h00 && r.cnt != SPI_BITS)
        next_r.err = 1'b1;
      next_r.cnt = 5'h00;
    end
    else if (!fr.cs_n && r.sck_q && !fr.sck && r.cnt != SPI_CNT_MAX)
      next_r.cnt = r.cnt + 5'h01; // Saturates so long frames stay wrong
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '{cs_q: 1'b1, sck_q: 1'b0, cnt: 5'h00, err: 1'b0};
    else
      r <= next_r;
  end

  assign fr.frame_err = r.err;
endmodule
`default_nettype wire

// ===== hw/efi_event_unit.sv
// Functional notes
// - Transmit time-out flag sets when data stays low past period in normal mode.
// - Buck unregulated flag sets on every change; live bit shows present state.
// - Buck overload flag sets on every change; live bit shows present state.
// - Boost activity flag sets when boost starts or stops; live bit shows it.
// - Boost overload flag sets on every change; live bit shows present state.
// - Thermal warning flag sets on crossings; cleared by status A read-clear.
// - Watchdog error flag sets only in development configuration; no live bit.
// - Watchdog error gives one interrupt pulse per occurrence, never repeated.
// - Aux under-voltage flag sets on detector change only while output is on.
// - Aux over-voltage flag sets on detector change regardless of output state.
// - Serial frame error when clock edge count is neither zero nor sixteen.
// - Serial frame error when clock is high at a select edge; host keeps low.
// - Five unmaskable wake flags, cleared by status B read-clear.
// - Wake flag sets only when that source's wake enable is on.
// - Clearing a flag never disturbs its live status bit.
// - LIN transmit time-out detection can be switched on or off.
// - Spurious select or clock toggling alters nothing but the frame error flag.
// - Every event sets its flag; masked events never pull the interrupt low.
// - Interrupt low for fixed time; repeats no sooner than inactive interval.
// - Reset mode clears all non-wake flags and masks every maskable event.
`timescale 1ns/1ps
`default_nettype none
module efi_event_unit
  import efi_pkg::*;
#(
  parameter int TO_CYC    = efi_pkg::TXD_TO_CYC,
  parameter int ACT_CYC   = efi_pkg::INT_ACT_CYC,
  parameter int INACT_CYC = efi_pkg::INT_INACT_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     reset_mode,
  input  wire logic                     can_normal,
  input  wire logic                     lin1_normal,
  input  wire logic                     lin2_normal,
  input  wire logic                     lin1_to_en,
  input  wire logic                     lin2_to_en,
  input  wire logic                     txd_can,
  input  wire logic                     txd_lin1,
  input  wire logic                     txd_lin2,
  input  wire logic                     buck_unreg_in,
  input  wire logic                     buck_ol_in,
  input  wire logic                     boost_run_in,
  input  wire logic                     boost_ol_in,
  input  wire logic                     twar_in,
  input  wire logic                     aux_under_in,
  input  wire logic                     aux_over_in,
  input  wire logic                     aux_regulator_on,
  input  wire logic                     sw_dev_cfg,
  input  wire logic                     wd_error,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_sck,
  input  wire logic [efi_pkg::WK_N-1:0] wake_det,
  input  wire logic [efi_pkg::WK_N-1:0] wake_en,
  input  wire logic                     irq_en_wr,
  input  wire logic [efi_pkg::EV_N-1:0] irq_en_wdata,
  input  wire logic                     rc_status_a,
  input  wire logic                     rc_status_b,
  output logic      [efi_pkg::EV_N-1:0] event_status_reg_a,
  output logic      [efi_pkg::WK_N-1:0] wake_status_reg_b,
  output logic      [efi_pkg::EV_N-1:0] rd_status_a,
  output logic      [efi_pkg::WK_N-1:0] rd_status_b,
  output logic      [efi_pkg::EV_N-1:0] irq_en,
  output logic                          buck_unregulated_now,
  output logic                          buck_overload_now,
  output logic                          boost_running_now,
  output logic                          boost_overload_now,
  output logic                          thermal_warn_now,
  output logic                          aux_supply_under_now,
  output logic                          aux_supply_over_now,
  output logic                          irq_out_n,
  output logic                          irq_out_oe_n
);
  import efi_pkg::*;

  typedef struct packed {
    logic [EV_N-1:0]           flags;
    logic [WK_N-1:0]           wake;
    logic [EV_N-1:0]           mask;
    logic [EV_N-1:0]           snap_a;
    logic [WK_N-1:0]           snap_b;
    logic [ST_N-1:0]           prev;
    logic [2:0][CNT_W-1:0]     to_cnt;
    logic                      wd_req;
    efi_irq_e                  st;
    logic [CNT_W-1:0]          cnt;
    logic                      irq_n;
  } efi_unit_s;

  localparam logic [CNT_W-1:0] TO_MAX    = CNT_W'(TO_CYC);
  localparam logic [CNT_W-1:0] ACT_END   = CNT_W'(ACT_CYC - 1);
  localparam logic [CNT_W-1:0] INACT_END = CNT_W'(INACT_CYC - 1);

  efi_unit_s       r;
  efi_unit_s       next_r;
  logic [11:0]     s_all;
  logic [2:0]      s_txd;
  logic [ST_N-1:0] s_stat;
  logic [2:0]      norm;
  logic [2:0]      to_on;
  logic [EV_N-1:0] ev;
  logic [ST_N-1:0] chg;
  logic            pend;
  efi_frame_if     fr ();

  // All pin and analog levels cross into the clock domain here
  efi_sync #(.W(12), .RV(12'h807)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({spi_cs_n, spi_sck, aux_over_in, aux_under_in, twar_in, boost_ol_in,
             boost_run_in, buck_ol_in, buck_unreg_in, txd_lin2, txd_lin1, txd_can}),
    .q     (s_all)
  );

  assign s_txd   = s_all[2:0];
  assign s_stat  = s_all[9:3];
  assign fr.sck  = s_all[10];
  assign fr.cs_n = s_all[11];

  // The frame checker's only output is the error event
  efi_frame_chk u_frame (
    .clk   (clk),
    .rst_n (rst_n),
    .fr    (fr.chk)
  );

  assign norm  = {lin2_normal, lin1_normal, can_normal};
  assign to_on = {lin2_to_en, lin1_to_en, 1'b1};
  assign chg   = s_stat ^ r.prev;

  // Event detection; live levels are sampled as they are, never touched by clears
  always_comb
  begin
    next_r      = r;
    ev          = '0;
    next_r.prev = s_stat;
    for (int i = 0; i < 3; i++)
    begin
      if (s_txd[i] || !norm[i] || !to_on[i])
        next_r.to_cnt[i] = '0;
      else if (r.to_cnt[i] != TO_MAX)
        next_r.to_cnt[i] = r.to_cnt[i] + 1'b1;
      // Holding at the limit re-fires every cycle, so a clear cannot stick
      ev[EV_CAN_TO + i] = !s_txd[i] && norm[i] && to_on[i]
                          && r.to_cnt[i] == TO_MAX;
    end
    ev[EV_BUCK_UNREG +: 5] = chg[4:0];
    ev[EV_WD]         = wd_error && sw_dev_cfg;
    ev[EV_AUX_UNDER]  = chg[5] && aux_regulator_on;
    ev[EV_AUX_OVER]   = chg[6];
    // Power-up glitches on select or clock reach only this bit
    ev[EV_FRAME]      = fr.frame_err;

    // Read-clear hands back the old flags, then new events are ORed in
    if (rc_status_a)
    begin
      next_r.snap_a = r.flags;
      next_r.flags  = FLAG_RST;
    end
    if (rc_status_b)
    begin
      next_r.snap_b = r.wake;
      next_r.wake   = WAKE_RST;
    end
    next_r.flags = next_r.flags | ev;
    next_r.wake  = next_r.wake | (wake_det & wake_en);
    if (irq_en_wr)
      next_r.mask = irq_en_wdata;

    // Interrupt pulse sequencer
    unique case (r.st)
      EFI_IDLE:
      begin
        if (pend)
        begin
          next_r.st     = EFI_LOW;
          next_r.cnt    = '0;
          next_r.irq_n  = 1'b0;
          next_r.wd_req = 1'b0;
        end
      end
      EFI_LOW:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == ACT_END)
        begin
          next_r.st    = EFI_GAP;
          next_r.cnt   = '0;
          next_r.irq_n = 1'b1;
        end
      end
      EFI_GAP:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt == INACT_END)
          next_r.st = EFI_IDLE;
      end
    endcase
    // A fresh watchdog miss arms exactly one more pulse
    if (ev[EV_WD] && r.mask[EV_WD])
      next_r.wd_req = 1'b1;

    // Reset mode wipes event flags and masks but keeps wake flags
    if (reset_mode)
    begin
      next_r.flags  = FLAG_RST;
      next_r.mask   = MASK_RST;
      next_r.wd_req = 1'b0;
    end
  end

  // Watchdog flag is excluded here: it only requests through wd_req
  assign pend = |(r.flags & r.mask & ~WD_BIT) || |r.wake || r.wd_req;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r        <= '0;
      r.st     <= EFI_IDLE;
      r.irq_n  <= 1'b1;
    end
    else
      r <= next_r;
  end

  // Outputs straight from the state register
  assign event_status_reg_a   = r.flags;
  assign wake_status_reg_b    = r.wake;
  assign rd_status_a          = r.snap_a;
  assign rd_status_b          = r.snap_b;
  assign irq_en               = r.mask;
  assign buck_unregulated_now = r.prev[0];
  assign buck_overload_now    = r.prev[1];
  assign boost_running_now    = r.prev[2];
  assign boost_overload_now   = r.prev[3];
  assign thermal_warn_now     = r.prev[4];
  assign aux_supply_under_now = r.prev[5];
  assign aux_supply_over_now  = r.prev[6];
  assign irq_out_n            = r.irq_n;
  assign irq_out_oe_n         = r.irq_n;

  // Checks
  property p_masked_quiet;
    @(posedge clk) disable iff (!rst_n)
      (r.st == EFI_IDLE && !pend) |=> r.irq_n;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq without pending");

  property p_low_len;
    @(posedge clk) disable iff (!rst_n)
      (r.st == EFI_LOW && r.cnt == ACT_END) |=> (r.irq_n && r.st == EFI_GAP && r.cnt == '0);
  endproperty
  a_low_len: assert property (p_low_len) else $error("irq low time wrong");

  property p_fall_idle;
    @(posedge clk) disable iff (!rst_n)
      $fell(r.irq_n) |-> ($past(r.st) == EFI_IDLE && r.st == EFI_LOW);
  endproperty
  a_fall_idle: assert property (p_fall_idle) else $error("irq fell during gap");

  property p_reset_mode;
    @(posedge clk) disable iff (!rst_n)
      reset_mode |=> (r.flags == FLAG_RST && r.mask == MASK_RST
                      && r.wake == (($past(rc_status_b) ? WAKE_RST : $past(r.wake))
                                    | $past(wake_det & wake_en)));
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode clear wrong");

  property p_rc_snap;
    @(posedge clk) disable iff (!rst_n)
      (rc_status_a && !reset_mode) |=> (r.snap_a == $past(r.flags) && r.flags == $past(ev));
  endproperty
  a_rc_snap: assert property (p_rc_snap) else $error("read-clear snapshot wrong");

  property p_txd_to;
    @(posedge clk) disable iff (!rst_n)
      (r.to_cnt[0] == TO_MAX && !s_txd[0] && can_normal && !reset_mode) |=> r.flags[EV_CAN_TO];
  endproperty
  a_txd_to: assert property (p_txd_to) else $error("tx time-out flag missing");

  property p_live_kept;
    @(posedge clk) disable iff (!rst_n)
      rc_status_a |=> (buck_unregulated_now == $past(s_stat[0]) && thermal_warn_now == $past(s_stat[4]));
  endproperty
  a_live_kept: assert property (p_live_kept) else $error("live bit disturbed");

  property p_wd_cfg;
    @(posedge clk) disable iff (!rst_n)
      (!sw_dev_cfg && !r.flags[EV_WD]) |=> !r.flags[EV_WD];
  endproperty
  a_wd_cfg: assert property (p_wd_cfg) else $error("wd flag outside dev config");

  property p_wake_en;
    @(posedge clk) disable iff (!rst_n)
      ((wake_det & wake_en) == '0 && r.wake == '0) |=> r.wake == '0;
  endproperty
  a_wake_en: assert property (p_wake_en) else $error("wake flag without enable");
endmodule
`default_nettype wire

// ===== sim/efi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module efi_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [4:0] n_edges,
  input  wire logic       sck_hi,
  input  wire logic       irq_out_n,
  output logic            spi_cs_n,
  output logic            spi_sck,
  output logic            busy,
  output logic [7:0]      n_pulses
);
  logic irq_q;
  // Count request pulses; the pin is sampled like a host port would
  always @(posedge clk)
  begin
    irq_q <= irq_out_n;
    if (!rst_n)
      n_pulses <= 8'h00;
    else if (irq_q === 1'b1 && irq_out_n === 1'b0)
      n_pulses <= n_pulses + 8'h01;
  end
  // Frame player; the serial clock stands low between frames
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        busy <= 1'b1;
        spi_cs_n <= 1'b0;
        repeat (3) @(posedge clk);
        repeat (n_edges)
        begin
          spi_sck <= 1'b1;
          repeat (2) @(posedge clk);
          spi_sck <= 1'b0;
          repeat (2) @(posedge clk);
        end
        // Clock parked low at select edges unless a fault is commanded
        spi_sck <= sck_hi;
        repeat (2) @(posedge clk);
        spi_cs_n <= 1'b1;
        repeat (2) @(posedge clk);
        spi_sck <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/efi_event_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module efi_event_unit_tb;
  import efi_pkg::*;
  localparam int TO = 8;
  localparam int ACT = 4;
  localparam int GAP = 6;
  logic clk, rst_n, rmode, aux_on, dcfg, wd, mwr, rca, rcb, go, hi;
  logic [2:0] nm, txd;
  logic [1:0] te;
  logic [6:0] lv;
  logic [4:0] wdet, wen, ne;
  logic [11:0] mdat;
  wire logic [11:0] sa, ra, msk;
  wire logic [4:0] sb, rb;
  wire logic [6:0] nw;
  wire logic irq_n, oe_n, cs_n, sck, busy;
  wire logic [7:0] np;
  logic [7:0] p;
  int errors, n_tests, f, lo, hg;
  logic [4:0] fn [5] = '{5'h10, 5'h00, 5'h05, 5'h0F, 5'h10};
  logic fh [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic fe [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  efi_event_unit #(.TO_CYC(TO), .ACT_CYC(ACT), .INACT_CYC(GAP)) dut_u (
    .clk(clk), .rst_n(rst_n), .reset_mode(rmode), .can_normal(nm[0]),
    .lin1_normal(nm[1]), .lin2_normal(nm[2]), .lin1_to_en(te[0]), .lin2_to_en(te[1]),
    .txd_can(txd[0]), .txd_lin1(txd[1]), .txd_lin2(txd[2]), .buck_unreg_in(lv[0]),
    .buck_ol_in(lv[1]), .boost_run_in(lv[2]), .boost_ol_in(lv[3]), .twar_in(lv[4]),
    .aux_under_in(lv[5]), .aux_over_in(lv[6]), .aux_regulator_on(aux_on),
    .sw_dev_cfg(dcfg), .wd_error(wd), .spi_cs_n(cs_n), .spi_sck(sck),
    .wake_det(wdet), .wake_en(wen), .irq_en_wr(mwr), .irq_en_wdata(mdat),
    .rc_status_a(rca), .rc_status_b(rcb), .event_status_reg_a(sa),
    .wake_status_reg_b(sb), .rd_status_a(ra), .rd_status_b(rb), .irq_en(msk),
    .buck_unregulated_now(nw[0]), .buck_overload_now(nw[1]), .boost_running_now(nw[2]),
    .boost_overload_now(nw[3]), .thermal_warn_now(nw[4]), .aux_supply_under_now(nw[5]),
    .aux_supply_over_now(nw[6]), .irq_out_n(irq_n), .irq_out_oe_n(oe_n));

  // Host sees the open-drain pin: low only while it is both enabled and driven low
  efi_host_model host_u (.clk(clk), .rst_n(rst_n), .go(go), .n_edges(ne), .sck_hi(hi),
    .irq_out_n(oe_n | irq_n), .spi_cs_n(cs_n), .spi_sck(sck), .busy(busy), .n_pulses(np));

  // Clock and time-zero values of every input
  initial
  begin
    {clk, rst_n, rmode, aux_on, dcfg, wd, mwr, rca, rcb, go, hi} = 11'h000;
    {nm, te, lv, wdet, wen, ne, mdat} = 39'h0;
    txd = 3'h7;
    forever #5 clk = ~clk;
  end

  task automatic st(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rc(input bit b);
    @(posedge clk)
    begin
      rca <= !b;
      rcb <= b;
    end
    @(posedge clk)
    begin
      rca <= 1'b0;
      rcb <= 1'b0;
    end
    st(1);
  endtask

  task automatic mw(input logic [11:0] v);
    @(posedge clk)
    begin
      mwr <= 1'b1;
      mdat <= v;
    end
    @(posedge clk) mwr <= 1'b0;
    st(1);
  endtask

  task automatic fr(input logic [4:0] n, input logic h);
    @(posedge clk)
    begin
      ne <= n;
      hi <= h;
      go <= 1'b1;
    end
    @(posedge clk) go <= 1'b0;
    st(1);
    for (int k = 0; k < 300 && busy === 1'b1; k++) @(negedge clk);
    chk(busy, 1'b0);
  endtask

  // Low time of the next request pulse and the idle gap after it
  task automatic meas(output int l, output int h);
    l = 0;
    h = 0;
    for (int k = 0; k < 200 && irq_n !== 1'b0; k++) @(negedge clk);
    while (irq_n === 1'b0 && l < 200)
    begin
      l++;
      @(negedge clk);
    end
    while (irq_n === 1'b1 && h < 200)
    begin
      h++;
      @(negedge clk);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    st(3);
    chk({sa, msk[3:0]}, 16'h0000);
    chk({oe_n, irq_n}, 16'h0003);
    rc(1'b0);
    for (int j = 0; j < 5; j++)
    begin
      fr(fn[j], fh[j]);
      st(8);
      chk(sa[11], fe[j]);
      rc(1'b0);
    end
    // Under-voltage change ignored while the aux output is off
    @(posedge clk) lv[5] <= 1'b1;
    st(5);
    chk({nw[5], sa[9]}, 16'h0002);
    @(posedge clk) lv[5] <= 1'b0;
    st(5);
    chk(sa[9], 1'b0);
    // Output switched on only after the falling change has been seen
    @(posedge clk) aux_on <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      f = (i < 5) ? i + 3 : i + 4;
      for (int v = 1; v >= 0; v--)
      begin
        @(posedge clk) lv[i] <= v[0];
        st(5);
        chk({nw[i], sa[f]}, {14'h0, v[0], 1'b1});
        rc(1'b0);
        chk({ra[f], sa[f], nw[i]}, {13'h0, 2'b10, v[0]});
      end
    end
    for (int c = 0; c < 3; c++)
    begin
      @(posedge clk) txd[c] <= 1'b0;
      st(TO + 6);
      chk(sa[c], 1'b0);
      @(posedge clk) nm[c] <= 1'b1;
      st(TO + 6);
      chk(sa[c], c == 0);
      if (c > 0)
        @(posedge clk) te[c-1] <= 1'b1;
      st(TO + 6);
      chk(sa[c], 1'b1);
      rc(1'b0);
      chk(sa[c], 1'b1);
      @(posedge clk) txd[c] <= 1'b1;
      st(4);
      rc(1'b0);
      chk(sa[c], 1'b0);
    end
    // Masked event: flag only; unmasked: pulse timing
    @(posedge clk) lv[4] <= 1'b1;
    st(5);
    p = np;
    st(20);
    chk({np, 7'h0, sa[7]}, {p, 8'h01});
    mw(12'h080);
    chk(msk, 12'h080);
    meas(lo, hg);
    chk(16'(lo), 16'(ACT));
    chk(hg >= GAP && hg < 200, 1'b1);
    @(posedge clk) lv[4] <= 1'b0;
    st(5);
    mw(12'h100);
    rc(1'b0);
    st(ACT + GAP + 4);
    p = np;
    @(posedge clk) wd <= 1'b1;
    @(posedge clk) wd <= 1'b0;
    st(2);
    chk(sa[8], 1'b0);
    @(posedge clk) dcfg <= 1'b1;
    @(posedge clk) wd <= 1'b1;
    @(posedge clk) wd <= 1'b0;
    st(3 * (ACT + GAP));
    chk({np, 7'h0, sa[8]}, {p + 8'h01, 8'h01});
    rc(1'b0);
    // Watchdog error in the same cycle as the read-clear survives
    @(posedge clk)
    begin
      wd <= 1'b1;
      rca <= 1'b1;
    end
    @(posedge clk)
    begin
      wd <= 1'b0;
      rca <= 1'b0;
    end
    st(1);
    chk({ra[8], sa[8]}, 16'h0001);
    for (int w = 0; w < 5; w++)
    begin
      for (int e = 0; e < 2; e++)
      begin
        @(posedge clk)
        begin
          wen[w] <= e[0];
          wdet[w] <= 1'b1;
        end
        @(posedge clk) wdet[w] <= 1'b0;
        st(1);
        chk(sb[w], e[0]);
      end
    end
    mw(12'hFFF);
    @(posedge clk) rmode <= 1'b1;
    @(posedge clk) rmode <= 1'b0;
    st(1);
    chk({sa, sb[3:0]}, 16'h000F);
    chk({msk, sb[4]}, 16'h0001);
    rc(1'b1);
    chk({rb, 6'h0, sb}, 16'hF800);
    give_verdict();
  end

  // Watchdog far beyond the expected run length
  initial
  begin
    #300000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
